/* rtl/ccr_comparator_regs.sv */
// comparator control register bank: control, mode and input select registers
//
// How it works
// [RULE1] bit 6 reads sampled comparator result
// [RULE2] rising edge sets sticky bit 5 flag
// [RULE3] falling edge sets sticky bit 4 flag
// [RULE4] mode bit 5 enables rise interrupt
// [RULE5] mode bit 4 enables fall interrupt
// [RULE6] bits 3:2 select positive hysteresis level
// [RULE7] bits 1:0 select negative hysteresis level
// [RULE8] mode bits 1:0 speed, reset 0x2
// [RULE9] select bits 7:4 choose minus input
// [RULE10] select bits 3:0 choose plus input
// [RULE11] interrupt while enabled flag remains set
// [RULE12] enable bit powers core, freezes flags
`timescale 1ns/1ps
`default_nettype none
module ccr_comparator_regs (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // special-function-register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_write_in,
    input wire logic sfr_read_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // comparator decision from the analog core
    input wire logic compare_raw_in,
    // analog core controls
    output logic comparator_power_on_out,
    output logic [ccr_pkg::HYST_W-1:0] positive_hysteresis_level_out,
    output logic [ccr_pkg::HYST_W-1:0] negative_hysteresis_level_out,
    output logic [ccr_pkg::SPEED_W-1:0] response_speed_select_out,
    output logic [ccr_pkg::SEL_W-1:0] minus_input_select_out,
    output logic [ccr_pkg::SEL_W-1:0] plus_input_select_out,
    // interrupt request
    output logic comparator_irq_out
);

    // ==========================================================
    // address decode, shared by the write and read paths
    function automatic ccr_pkg::ccr_reg_sel_t decode_addr(input logic [7:0] addr);
        ccr_pkg::ccr_reg_sel_t sel;
        sel = ccr_pkg::CCR_SEL_NONE;
        if (addr == ccr_pkg::CONTROL_ADDR) begin
            sel = ccr_pkg::CCR_SEL_CONTROL;
        end else if (addr == ccr_pkg::MODE_ADDR) begin
            sel = ccr_pkg::CCR_SEL_MODE;
        end else if (addr == ccr_pkg::INPUT_SELECT_ADDR) begin
            sel = ccr_pkg::CCR_SEL_INPUT;
        end
        return sel;
    endfunction

    // ==========================================================
    // sticky flag update; a hardware set beats a same-cycle clear
    function automatic logic next_sticky(
        input logic current,
        input logic hw_set,
        input logic sw_write,
        input logic sw_value
    );
        logic result;
        result = current;
        if (sw_write) begin
            result = sw_value;
        end
        if (hw_set) begin
            result = 1'b1;
        end
        return result;
    endfunction

    // ==========================================================
    // register state
    logic power_on;
    logic rise_event_flag;
    logic fall_event_flag;
    logic [ccr_pkg::HYST_W-1:0] positive_hysteresis_level;
    logic [ccr_pkg::HYST_W-1:0] negative_hysteresis_level;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic [ccr_pkg::SPEED_W-1:0] response_speed_select;
    logic [ccr_pkg::SEL_W-1:0] minus_input_select;
    logic [ccr_pkg::SEL_W-1:0] plus_input_select;

    ccr_pkg::ccr_reg_sel_t access_sel;
    logic write_control;
    logic write_mode;
    logic write_input;

    assign access_sel = decode_addr(sfr_addr_in);

    always_comb begin
        write_control = 1'b0;
        write_mode = 1'b0;
        write_input = 1'b0;
        if (sfr_write_in) begin
            unique case (access_sel)
                ccr_pkg::CCR_SEL_CONTROL: begin
                    write_control = 1'b1;
                end
                ccr_pkg::CCR_SEL_MODE: begin
                    write_mode = 1'b1;
                end
                ccr_pkg::CCR_SEL_INPUT: begin
                    write_input = 1'b1;
                end
                ccr_pkg::CCR_SEL_NONE: begin
                    // unmapped writes are dropped with no error indication
                end
            endcase
        end
    end

    // ==========================================================
    // comparator output sampling and edge detection
    ccr_edge_if edge_bus ();

    assign edge_bus.power_on = power_on;

    ccr_edge_detect u_edge_detect (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .compare_raw_in(compare_raw_in),
        .edge_bus(edge_bus)
    );

    // ==========================================================
    // control register: comparator enable
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            power_on <= 1'b0;
        end else if (write_control) begin
            power_on <= sfr_wdata_in[ccr_pkg::CTL_POWER_BIT]; // [RULE12]
        end
    end

    // ==========================================================
    // control register: hysteresis fields
    // every code is legal, so none is range checked
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            positive_hysteresis_level <= ccr_pkg::HYST_RESET;
            negative_hysteresis_level <= ccr_pkg::HYST_RESET;
        end else if (write_control) begin
            positive_hysteresis_level <=
                sfr_wdata_in[ccr_pkg::CTL_HYST_POS_LSB +: ccr_pkg::HYST_W]; // [RULE6]
            negative_hysteresis_level <=
                sfr_wdata_in[ccr_pkg::CTL_HYST_NEG_LSB +: ccr_pkg::HYST_W]; // [RULE7]
        end
    end

    // ==========================================================
    // rising-edge flag: firmware may write either value, hardware only sets
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rise_event_flag <= 1'b0;
        end else begin
            rise_event_flag <= next_sticky(rise_event_flag, edge_bus.rise_pulse,
                write_control, sfr_wdata_in[ccr_pkg::CTL_RISE_FLAG_BIT]); // [RULE2]
        end
    end

    // ==========================================================
    // falling-edge flag: same policy as the rising-edge flag
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fall_event_flag <= 1'b0;
        end else begin
            fall_event_flag <= next_sticky(fall_event_flag, edge_bus.fall_pulse,
                write_control, sfr_wdata_in[ccr_pkg::CTL_FALL_FLAG_BIT]); // [RULE3]
        end
    end

    // ==========================================================
    // mode register enables; reserved bits are not stored and read fixed
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rise_irq_enable <= 1'b0;
            fall_irq_enable <= 1'b0;
        end else if (write_mode) begin
            rise_irq_enable <= sfr_wdata_in[ccr_pkg::MODE_RISE_EN_BIT]; // [RULE4]
            fall_irq_enable <= sfr_wdata_in[ccr_pkg::MODE_FALL_EN_BIT]; // [RULE5]
        end
    end

    // ==========================================================
    // mode register response speed
    // all four codes are legal, so none is refused
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            response_speed_select <= ccr_pkg::SPEED_RESET;
        end else if (write_mode) begin
            response_speed_select <=
                sfr_wdata_in[ccr_pkg::MODE_SPEED_LSB +: ccr_pkg::SPEED_W]; // [RULE8]
        end
    end

    // ==========================================================
    // input select register: minus input field
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            minus_input_select <= ccr_pkg::SEL_RESET;
        end else if (write_input) begin
            minus_input_select <=
                sfr_wdata_in[ccr_pkg::SEL_MINUS_LSB +: ccr_pkg::SEL_W]; // [RULE9]
        end
    end

    // ==========================================================
    // input select register: plus input field
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            plus_input_select <= ccr_pkg::SEL_RESET;
        end else if (write_input) begin
            plus_input_select <= sfr_wdata_in[ccr_pkg::SEL_PLUS_LSB +: ccr_pkg::SEL_W]; // [RULE10]
        end
    end

    // ==========================================================
    // read-back images of each register
    logic [7:0] control_image;
    logic [7:0] mode_image;
    logic [7:0] input_image;
    logic [7:0] next_rdata;

    always_comb begin
        control_image = 8'h00;
        control_image[ccr_pkg::CTL_POWER_BIT] = power_on;
        control_image[ccr_pkg::CTL_RESULT_BIT] = edge_bus.sampled_compare_result; // [RULE1]
        control_image[ccr_pkg::CTL_RISE_FLAG_BIT] = rise_event_flag;
        control_image[ccr_pkg::CTL_FALL_FLAG_BIT] = fall_event_flag;
        control_image[ccr_pkg::CTL_HYST_POS_LSB +: ccr_pkg::HYST_W] = positive_hysteresis_level;
        control_image[ccr_pkg::CTL_HYST_NEG_LSB +: ccr_pkg::HYST_W] = negative_hysteresis_level;
    end

    always_comb begin
        mode_image = 8'h00;
        mode_image[ccr_pkg::MODE_RESV_HI_LSB +: ccr_pkg::RESV_W] = ccr_pkg::MODE_RESV_HI_VALUE;
        mode_image[ccr_pkg::MODE_RISE_EN_BIT] = rise_irq_enable;
        mode_image[ccr_pkg::MODE_FALL_EN_BIT] = fall_irq_enable;
        mode_image[ccr_pkg::MODE_RESV_LO_LSB +: ccr_pkg::RESV_W] = ccr_pkg::MODE_RESV_LO_VALUE;
        mode_image[ccr_pkg::MODE_SPEED_LSB +: ccr_pkg::SPEED_W] = response_speed_select;
    end

    always_comb begin
        input_image = 8'h00;
        input_image[ccr_pkg::SEL_MINUS_LSB +: ccr_pkg::SEL_W] = minus_input_select;
        input_image[ccr_pkg::SEL_PLUS_LSB +: ccr_pkg::SEL_W] = plus_input_select;
    end

    always_comb begin
        unique case (access_sel)
            ccr_pkg::CCR_SEL_CONTROL: begin
                next_rdata = control_image;
            end
            ccr_pkg::CCR_SEL_MODE: begin
                next_rdata = mode_image;
            end
            ccr_pkg::CCR_SEL_INPUT: begin
                next_rdata = input_image;
            end
            ccr_pkg::CCR_SEL_NONE: begin
                next_rdata = ccr_pkg::UNMAPPED_READ;
            end
        endcase
    end

    // ==========================================================
    // read data is registered and held until the next read strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_read_in) begin
            sfr_rdata_out <= next_rdata;
        end
    end

    // ==========================================================
    // interrupt request stays up while an enabled flag is set
    logic rise_irq_request;
    logic fall_irq_request;

    assign rise_irq_request = rise_event_flag & rise_irq_enable; // [RULE4]
    assign fall_irq_request = fall_event_flag & fall_irq_enable; // [RULE5]

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            comparator_irq_out <= 1'b0;
        end else begin
            comparator_irq_out <= rise_irq_request | fall_irq_request; // [RULE11]
        end
    end

    // ==========================================================
    // analog core controls
    assign comparator_power_on_out = power_on; // [RULE12]
    assign positive_hysteresis_level_out = positive_hysteresis_level; // [RULE6]
    assign negative_hysteresis_level_out = negative_hysteresis_level; // [RULE7]
    assign response_speed_select_out = response_speed_select; // [RULE8]
    assign minus_input_select_out = minus_input_select; // [RULE9]
    assign plus_input_select_out = plus_input_select; // [RULE10]

endmodule
`default_nettype wire

/* rtl/ccr_pkg.sv */
// constants shared by the comparator control register bank
package ccr_pkg;

    // ==========================================================
    // register addresses in special-function-register space
    localparam logic [7:0] CONTROL_ADDR = 8'h9A;
    localparam logic [7:0] MODE_ADDR = 8'h9C;
    localparam logic [7:0] INPUT_SELECT_ADDR = 8'h9F;

    // ==========================================================
    // control register field positions
    localparam int CTL_POWER_BIT = 7;
    localparam int CTL_RESULT_BIT = 6;
    localparam int CTL_RISE_FLAG_BIT = 5;
    localparam int CTL_FALL_FLAG_BIT = 4;
    localparam int CTL_HYST_POS_LSB = 2;
    localparam int CTL_HYST_NEG_LSB = 0;

    // ==========================================================
    // mode register field positions
    localparam int MODE_RESV_HI_LSB = 6;
    localparam int MODE_RISE_EN_BIT = 5;
    localparam int MODE_FALL_EN_BIT = 4;
    localparam int MODE_RESV_LO_LSB = 2;
    localparam int MODE_SPEED_LSB = 0;

    // ==========================================================
    // input select register field positions
    localparam int SEL_MINUS_LSB = 4;
    localparam int SEL_PLUS_LSB = 0;

    // ==========================================================
    // field widths and reset values
    localparam int HYST_W = 2;
    localparam int SPEED_W = 2;
    localparam int SEL_W = 4;
    localparam int RESV_W = 2;
    localparam logic [HYST_W-1:0] HYST_RESET = 2'h0;
    localparam logic [SPEED_W-1:0] SPEED_RESET = 2'h2;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'hF;
    localparam logic [RESV_W-1:0] MODE_RESV_HI_VALUE = 2'h2;
    localparam logic [RESV_W-1:0] MODE_RESV_LO_VALUE = 2'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // decoded register selection
    typedef enum logic [1:0] {
        CCR_SEL_NONE = 2'b00,
        CCR_SEL_CONTROL = 2'b01,
        CCR_SEL_MODE = 2'b10,
        CCR_SEL_INPUT = 2'b11
    } ccr_reg_sel_t;

endpackage

/* rtl/ccr_edge_if.sv */
// carrier between the register bank and the comparator output sampler
`timescale 1ns/1ps
`default_nettype none
interface ccr_edge_if;
    logic power_on;
    logic sampled_compare_result;
    logic rise_pulse;
    logic fall_pulse;

    modport regs (
        output power_on,
        input sampled_compare_result,
        input rise_pulse,
        input fall_pulse
    );
    modport sampler (
        input power_on,
        output sampled_compare_result,
        output rise_pulse,
        output fall_pulse
    );
endinterface
`default_nettype wire

/* rtl/ccr_edge_detect.sv */
// comparator output synchroniser, sample holder and edge detector
`timescale 1ns/1ps
`default_nettype none
module ccr_edge_detect (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // raw comparator decision from the analog core
    input wire logic compare_raw_in,
    // register bank side
    ccr_edge_if.sampler edge_bus
);

    // ==========================================================
    // two-stage synchroniser; the analog decision is asynchronous
    logic sync_first;
    logic sync_second;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first <= compare_raw_in;
            sync_second <= sync_first;
        end
    end

    // ==========================================================
    // sampled result holds its last value while powered down
    logic sampled;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sampled <= 1'b0;
        end else if (edge_bus.power_on) begin
            sampled <= sync_second; // [RULE1] [RULE12]
        end
    end

    // ==========================================================
    // edge pulses only while powered; a held sample can fake one at power-up
    assign edge_bus.sampled_compare_result = sampled;
    assign edge_bus.rise_pulse = edge_bus.power_on & sync_second & ~sampled; // [RULE2] [RULE12]
    assign edge_bus.fall_pulse = edge_bus.power_on & ~sync_second & sampled; // [RULE3] [RULE12]

endmodule
`default_nettype wire

/* dv/ccr_checker.sv */
// concurrent assertions for the comparator control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register access
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_write_in,
    input wire logic sfr_read_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // analog core side
    input wire logic compare_raw_in,
    input wire logic comparator_power_on_out,
    input wire logic [1:0] positive_hysteresis_level_out,
    input wire logic [1:0] negative_hysteresis_level_out,
    input wire logic [1:0] response_speed_select_out,
    input wire logic [3:0] minus_input_select_out,
    input wire logic [3:0] plus_input_select_out,
    input wire logic comparator_irq_out
);
    // =====
    // access decode
    logic wr_ctl, wr_mode, wr_sel, rd_ctl, rd_mode, rd_sel;
    assign wr_ctl = sfr_write_in && sfr_addr_in == ccr_pkg::CONTROL_ADDR;
    assign wr_mode = sfr_write_in && sfr_addr_in == ccr_pkg::MODE_ADDR;
    assign wr_sel = sfr_write_in && sfr_addr_in == ccr_pkg::INPUT_SELECT_ADDR;
    assign rd_ctl = sfr_read_in && sfr_addr_in == ccr_pkg::CONTROL_ADDR;
    assign rd_mode = sfr_read_in && sfr_addr_in == ccr_pkg::MODE_ADDR;
    assign rd_sel = sfr_read_in && sfr_addr_in == ccr_pkg::INPUT_SELECT_ADDR;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // =====
    // properties
    a_power_write: assert property (wr_ctl |=>
        comparator_power_on_out == $past(sfr_wdata_in[7]))
        else $error("power enable not loaded");
    a_hyst_write: assert property (wr_ctl |=>
        {positive_hysteresis_level_out, negative_hysteresis_level_out} ==
        $past(sfr_wdata_in[3:0])) else $error("hysteresis wrong");
    a_speed_write: assert property (wr_mode |=>
        response_speed_select_out == $past(sfr_wdata_in[1:0])) else $error("speed not loaded");
    a_speed_hold: assert property (!wr_mode |=> $stable(response_speed_select_out))
        else $error("speed changed without write");
    a_select_write: assert property (wr_sel |=>
        {minus_input_select_out, plus_input_select_out} == $past(sfr_wdata_in))
        else $error("input select wrong");
    a_ctl_readback: assert property (rd_ctl |=>
        sfr_rdata_out[7] == $past(comparator_power_on_out) &&
        sfr_rdata_out[3:2] == $past(positive_hysteresis_level_out) &&
        sfr_rdata_out[1:0] == $past(negative_hysteresis_level_out)) else $error("control read");
    a_mode_readback: assert property (rd_mode |=> sfr_rdata_out[7:6] == 2'h2 &&
        sfr_rdata_out[1:0] == $past(response_speed_select_out)) else $error("mode read wrong");
    a_sel_readback: assert property (rd_sel |=> sfr_rdata_out ==
        {$past(minus_input_select_out), $past(plus_input_select_out)}) else $error("select read");
    a_irq_masked: assert property (wr_mode && sfr_wdata_in[5:4] == 2'h0 |-> ##2
        !comparator_irq_out) else $error("irq stays with enables off");
    c_irq_rise: cover property ($rose(comparator_irq_out));
    c_raw_rise: cover property (comparator_power_on_out && $rose(compare_raw_in));
    c_sel_write: cover property (wr_sel);
endmodule
bind ccr_comparator_regs ccr_checker ccr_checker_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .sfr_addr_in(sfr_addr_in), .sfr_write_in(sfr_write_in), .sfr_read_in(sfr_read_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .compare_raw_in(compare_raw_in),
    .comparator_power_on_out(comparator_power_on_out),
    .positive_hysteresis_level_out(positive_hysteresis_level_out),
    .negative_hysteresis_level_out(negative_hysteresis_level_out),
    .response_speed_select_out(response_speed_select_out),
    .minus_input_select_out(minus_input_select_out),
    .plus_input_select_out(plus_input_select_out), .comparator_irq_out(comparator_irq_out));
`default_nettype wire

/* dv/ccr_analog_model.sv */
// behavioural model of the analog comparator core
`timescale 1ns/1ps
`default_nettype none
module ccr_analog_model (
    // clock and power
    input wire logic clk_in,
    input wire logic power_on_in,
    // input levels in arbitrary steps
    input wire logic [7:0] plus_level_in,
    input wire logic [7:0] minus_level_in,
    // decision
    output logic compare_out
);
    logic idle_toggle = 1'b0;
    // an unpowered core gives no valid decision, so it is modelled as noise
    always @(posedge clk_in) begin
        idle_toggle <= ~idle_toggle;
    end
    always_comb begin
        if (power_on_in) begin
            compare_out = plus_level_in > minus_level_in;
        end else begin
            compare_out = idle_toggle;
        end
    end
endmodule
`default_nettype wire

/* dv/ccr_comparator_regs_test.sv */
// self-checking testbench for the comparator control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_comparator_regs_test;
    localparam logic [7:0] CTL = ccr_pkg::CONTROL_ADDR;
    localparam logic [7:0] MOD = ccr_pkg::MODE_ADDR;
    localparam logic [7:0] SEL = ccr_pkg::INPUT_SELECT_ADDR;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_write_in = 1'b0;
    logic sfr_read_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] plus_level = 8'h10;
    logic [7:0] minus_level = 8'h80;
    logic [7:0] sfr_rdata_out, v;
    logic compare_raw_in, power_on, irq;
    logic [1:0] pos_hyst, neg_hyst, speed;
    logic [3:0] minus_sel, plus_sel;
    int errors = 0;
    int tests_run = 0;
    always #5 clk_in = ~clk_in;
    ccr_comparator_regs ccr_comparator_regs_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .sfr_addr_in(sfr_addr_in), .sfr_write_in(sfr_write_in), .sfr_read_in(sfr_read_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .compare_raw_in(compare_raw_in), .comparator_power_on_out(power_on),
        .positive_hysteresis_level_out(pos_hyst), .negative_hysteresis_level_out(neg_hyst),
        .response_speed_select_out(speed), .minus_input_select_out(minus_sel),
        .plus_input_select_out(plus_sel), .comparator_irq_out(irq));
    ccr_analog_model ccr_analog_model_inst (.clk_in(clk_in), .power_on_in(power_on),
        .plus_level_in(plus_level), .minus_level_in(minus_level), .compare_out(compare_raw_in));
    // =====
    // access tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED time=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        sfr_addr_in = addr;
        sfr_wdata_in = data;
        sfr_write_in = 1'b1;
        @(negedge clk_in);
        sfr_write_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_in);
        sfr_addr_in = addr;
        sfr_read_in = 1'b1;
        @(negedge clk_in);
        sfr_read_in = 1'b0;
        check(sfr_rdata_out, exp);
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a full run takes well under 1000 cycles
    initial begin
        #50000;
        errors++;
        $display("watchdog expired");
        summarize();
    end
    // =====
    // tests
    initial begin
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        reset_n_in = 1'b1;
        check({6'h00, speed}, 8'h02);
        check({minus_sel, plus_sel}, 8'hFF);
        check({3'h0, irq, pos_hyst, neg_hyst}, 8'h00);
        rd(CTL, 8'h00);
        rd(MOD, 8'h82);
        rd(SEL, 8'hFF);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            v = {4'h0, 2'(i), 2'(3 - i)};
            wr(CTL, v);
            check({4'h0, pos_hyst, neg_hyst}, v);
            rd(CTL, v);
            wr(MOD, {2'h1, 2'h0, 2'h3, 2'(i)});
            check({6'h00, speed}, 8'(i));
            rd(MOD, {6'h20, 2'(i)});
            v = {4'(3 * i + 1), 4'(14 - 3 * i)};
            wr(SEL, v);
            check({minus_sel, plus_sel}, v);
            rd(SEL, v);
        end
        wr(8'h9B, 8'hFF);
        rd(8'h9B, 8'h00);
        rd(SEL, v);
        $display("test field_access done");
        wr(MOD, 8'h30);
        wr(CTL, 8'h80);
        repeat (6) @(negedge clk_in);
        wr(CTL, 8'h80);
        rd(CTL, 8'h80);
        plus_level = 8'hC0;
        repeat (5) @(negedge clk_in);
        rd(CTL, 8'hE0);
        check({7'h00, irq}, 8'h01);
        plus_level = 8'h10;
        repeat (5) @(negedge clk_in);
        rd(CTL, 8'hB0);
        wr(CTL, 8'h90);
        rd(CTL, 8'h90);
        check({7'h00, irq}, 8'h01);
        wr(CTL, 8'h80);
        @(negedge clk_in);
        check({7'h00, irq}, 8'h00);
        wr(MOD, 8'h10);
        plus_level = 8'hC0;
        repeat (5) @(negedge clk_in);
        rd(CTL, 8'hE0);
        check({7'h00, irq}, 8'h00);
        plus_level = 8'h10;
        repeat (5) @(negedge clk_in);
        check({7'h00, irq}, 8'h01);
        $display("test edge_flags done");
        wr(CTL, 8'h00);
        plus_level = 8'hC0;
        repeat (8) @(negedge clk_in);
        rd(CTL, 8'h00);
        check({6'h00, power_on, irq}, 8'h00);
        $display("test power_off done");
        summarize();
    end
endmodule
`default_nettype wire
